/* rtl/cci_pkg.sv */
// constants shared by the console controller input block
// assumes a 20 MHz ref_clk and an 8-bit register port with a 4-bit address
package cci_pkg;
   // register port widths and offsets
   localparam int          DATA_W          = 8;
   localparam int          ADDR_W          = 4;
   localparam logic [3:0]  ADR_CONSOLE     = 4'h0; // console_switch_outputs
   localparam logic [3:0]  ADR_SKCTRL      = 4'h1; // serial_keyboard_control
   localparam logic [3:0]  ADR_SCAN_CODE   = 4'h2; // key_scan_code
   localparam logic [3:0]  ADR_SKSTATUS    = 4'h3; // serial_keyboard_status
   localparam logic [3:0]  ADR_IRQ_STATUS  = 4'h4; // interrupt_status, write one to clear
   localparam logic [3:0]  ADR_IRQ_MASK    = 4'h5;
   localparam logic [3:0]  ADR_FIRE        = 4'h6; // fire_button_inputs
   localparam logic [3:0]  ADR_PADDLE_BASE = 4'h8; // paddle_count 0..7 at 8..F

   // field positions
   localparam int          CON_SEL_LSB     = 0;    // controller select, two bits
   localparam int          CON_POT_POWER   = 2;    // stick power and trackball calibration
   localparam int          SKC_DEBOUNCE    = 0;
   localparam int          SKS_KEY_DOWN    = 2;
   localparam int          SKS_SHIFT       = 3;
   localparam int          IRQ_KEY         = 6;
   localparam int          IRQ_BREAK       = 7;

   // values after reset
   localparam logic [7:0]  RST_CONSOLE     = 8'h00;
   localparam logic [7:0]  RST_SKCTRL      = 8'h00;
   localparam logic [7:0]  RST_SCAN_CODE   = 8'h00;
   localparam logic [7:0]  RST_IRQ         = 8'h00;
   localparam logic [7:0]  RST_MASK        = 8'h00;

   // paddle count ceiling, also the value read while pots are unpowered
   localparam logic [7:0]  POT_MAX         = 8'hE4;

   // scan line timing: one keyboard scan code step per scan line
   localparam int          CLK_HZ          = 20_000_000;
   localparam int          SCAN_LINE_NS    = 64_000;
   localparam int          LINE_CYC        = (SCAN_LINE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
   localparam logic [11:0] LINE_LAST       = 12'(LINE_CYC - 1);

   // game-control codes on scan-code bits 1 to 4
   localparam logic [3:0]  CODE_NONE       = 4'h0;
   localparam logic [3:0]  CODE_START      = 4'hC;
   localparam logic [3:0]  CODE_PAUSE      = 4'h8;
   localparam logic [3:0]  CODE_RESET      = 4'h4;

   // keyboard report state
   typedef enum logic [0:0] {
      CCI_IDLE         = 1'b0,
      CCI_WAIT_RELEASE = 1'b1
   } cci_kbd_state_type;
endpackage

/* rtl/cci_top.sv */
// console controller input: controller select, keypad scan, triggers, paddle counts
// assumes all controller pins are asynchronous to ref_clk and the register port is synchronous
//
// Design decisions made here: the register addresses and the strobed register port.
`timescale 1ns/1ps

// Contract
// - console bits 1:0 pick which controller keypad and top button are scanned
// - bottom buttons and sticks use per-controller inputs, ignoring the select bits
// - digit, star and hash keys encode on scan-code bits 1 to 4 per table
// - Start, Pause and Reset encode as 1100, 1000 and 0100
// - unused scan lines make every pressed key match four times per scan
// - debounce on sees duplicates as many keys, so nothing is reported
// - debounce off reports a held key again every 32 scan lines
// - debounce enabled within one line after a report waits for key release
// - console bit 2 powers pots; unpowered, every paddle count reads 228
// - console bit 2 line also serves trackball calibration and detection
// - even paddle inputs horizontal, low is left; odd vertical, low is up
// - each bottom button drives its own fire button input
// - top button acts as shift/control/break: break interrupt and top code bits
// - console switch lines are outputs only, never read back from pins
module cci_top
   import cci_pkg::*;
(
   input  wire logic                      ref_clk,
   input  wire logic                      arst_n,
   input  wire logic [cci_pkg::ADDR_W-1:0] reg_addr,
   input  wire logic [cci_pkg::DATA_W-1:0] reg_wdata,
   input  wire logic                      reg_write,
   input  wire logic                      reg_read,
   output logic      [cci_pkg::DATA_W-1:0] reg_rdata,
   output logic                           irq,
   output logic      [3:0]                console_lines,
   output logic                           pot_dump,
   input  wire logic [3:0][15:0]          keypad_n,
   input  wire logic [3:0]                top_button_n,
   input  wire logic [3:0]                fire_button_n,
   input  wire logic [7:0]                pot_in
);
   import cci_pkg::*;

   // true when a key code in scan bits 1 to 4 is one of the fifteen pad buttons
   function automatic logic code_valid(input logic [3:0] code);
      code_valid = (code != CODE_NONE);
   endfunction

   // pin synchronisers, two flops each
   logic [3:0][15:0] key_meta;
   logic [3:0][15:0] key_sync;
   logic [3:0]       top_meta;
   logic [3:0]       top_sync;
   logic [3:0]       fire_meta;
   logic [3:0]       fire_sync;
   logic [7:0]       pot_meta;
   logic [7:0]       pot_sync;

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         key_meta  <= '1;
         key_sync  <= '1;
         top_meta  <= '1;
         top_sync  <= '1;
         fire_meta <= '1;
         fire_sync <= '1;
         pot_meta  <= '0;
         pot_sync  <= '0;
      end else begin
         key_meta  <= keypad_n;
         key_sync  <= key_meta;
         top_meta  <= top_button_n;
         top_sync  <= top_meta;
         fire_meta <= fire_button_n;
         fire_sync <= fire_meta;
         pot_meta  <= pot_in;
         pot_sync  <= pot_meta;
      end
   end

   // software state and keyboard scan state
   logic [7:0]        console;
   logic [7:0]        skctrl;
   logic [7:0]        scan_code;
   logic [7:0]        irq_status;
   logic [7:0]        irq_mask;
   logic [11:0]       line_cnt;
   logic [5:0]        scan_step;
   logic [1:0]        scan_sel;
   logic              window;
   logic [5:0]        held_code;
   logic              top_prev;
   cci_kbd_state_type kbd_state;
   logic [7:0]        next_console;
   logic [7:0]        next_skctrl;
   logic [7:0]        next_scan_code;
   logic [7:0]        next_irq_status;
   logic [7:0]        next_irq_mask;
   logic [11:0]       next_line_cnt;
   logic [5:0]        next_scan_step;
   logic [1:0]        next_scan_sel;
   logic              next_window;
   logic [5:0]        next_held_code;
   logic              next_top_prev;
   cci_kbd_state_type next_kbd_state;
   logic              line_tick;
   logic              key_hit;
   logic              top_held;
   logic              debounce;
   logic              wr_irq;

   // scan line timing, key matching and register writes
   always_comb begin
      line_tick       = (line_cnt == LINE_LAST);
      debounce        = skctrl[SKC_DEBOUNCE];
      // only bits 1 to 4 reach the pads, so each key matches four steps per scan
      key_hit         = code_valid(scan_step[4:1]) && !key_sync[scan_sel][scan_step[4:1]];
      top_held        = !top_sync[scan_sel];
      wr_irq          = reg_write && (reg_addr == ADR_IRQ_STATUS);
      next_line_cnt   = line_tick ? 12'h000 : line_cnt + 12'h001;
      next_scan_step  = scan_step;
      next_scan_sel   = scan_sel;
      next_window     = window;
      next_scan_code  = scan_code;
      next_held_code  = held_code;
      next_kbd_state  = kbd_state;
      next_top_prev   = top_held;
      next_console    = console;
      next_skctrl     = skctrl;
      next_irq_mask   = irq_mask;
      next_irq_status = irq_status;
      if (reg_write) begin
         case (reg_addr)
            ADR_CONSOLE:  next_console  = reg_wdata;
            ADR_SKCTRL:   next_skctrl   = reg_wdata;
            ADR_IRQ_MASK: next_irq_mask = reg_wdata;
            default:      ;
         endcase
      end
      // write one to clear; events below are applied after, so a set wins
      if (wr_irq) begin
         next_irq_status = irq_status & ~reg_wdata;
      end
      if (top_held && !top_prev) begin
         next_irq_status[IRQ_BREAK] = 1'b1;
      end
      if (line_tick) begin
         next_scan_step = scan_step + 6'h01;
         next_window    = 1'b0;
         // controller select is only sampled at the end of a full scan
         if (scan_step == 6'h3F) begin
            next_scan_sel = console[CON_SEL_LSB +: 2];
         end
         case (kbd_state)
            CCI_IDLE: begin
               // with debounce on, the duplicate matches look like several keys: no report
               if (key_hit && !debounce) begin
                  next_scan_code                = {top_held, top_held, scan_step};
                  next_irq_status[IRQ_KEY]      = 1'b1;
                  next_held_code                = scan_step;
                  next_window                   = 1'b1;
               end
            end
            CCI_WAIT_RELEASE: begin
               // release is seen when the held key's own step finds it up
               if (!debounce || (scan_step == held_code && !key_hit)) begin
                  next_kbd_state = CCI_IDLE;
               end
            end
            default: next_kbd_state = CCI_IDLE;
         endcase
      end
      // debounce turned on within one line of a report holds that key
      if (window && debounce && kbd_state == CCI_IDLE) begin
         next_kbd_state = CCI_WAIT_RELEASE;
         next_window    = 1'b0;
      end
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         console    <= RST_CONSOLE;
         skctrl     <= RST_SKCTRL;
         scan_code  <= RST_SCAN_CODE;
         irq_status <= RST_IRQ;
         irq_mask   <= RST_MASK;
         line_cnt   <= 12'h000;
         scan_step  <= 6'h00;
         scan_sel   <= 2'h0;
         window     <= 1'b0;
         held_code  <= 6'h00;
         top_prev   <= 1'b0;
         kbd_state  <= CCI_IDLE;
      end else begin
         console    <= next_console;
         skctrl     <= next_skctrl;
         scan_code  <= next_scan_code;
         irq_status <= next_irq_status;
         irq_mask   <= next_irq_mask;
         line_cnt   <= next_line_cnt;
         scan_step  <= next_scan_step;
         scan_sel   <= next_scan_sel;
         window     <= next_window;
         held_code  <= next_held_code;
         top_prev   <= next_top_prev;
         kbd_state  <= next_kbd_state;
      end
   end

   // paddle measurement: one count per scan line until the pot input trips
   logic [7:0]      pot_cnt;
   logic [7:0][7:0] paddle;
   logic [7:0]      pot_done;
   logic            dump;
   logic [7:0]      next_pot_cnt;
   logic [7:0][7:0] next_paddle;
   logic [7:0]      next_pot_done;
   logic            next_dump;

   // each stick input has its own counter latch, independent of the select bits
   always_comb begin
      next_pot_cnt  = pot_cnt;
      next_paddle   = paddle;
      next_pot_done = pot_done;
      next_dump     = dump;
      if (line_tick) begin
         next_dump = 1'b0;
         if (pot_cnt == POT_MAX) begin
            next_pot_cnt  = 8'h00;
            next_pot_done = 8'h00;
            next_dump     = 1'b1;
         end else begin
            next_pot_cnt = pot_cnt + 8'h01;
         end
         for (int i = 0; i < 8; i++) begin
            // even inputs horizontal, odd vertical; the count itself gives direction
            if (!pot_done[i] && (pot_sync[i] || pot_cnt == POT_MAX)) begin
               next_paddle[i]   = pot_cnt;
               next_pot_done[i] = 1'b1;
            end
         end
      end
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         pot_cnt  <= 8'h00;
         paddle   <= {8{POT_MAX}};
         pot_done <= 8'h00;
         dump     <= 1'b1;
      end else begin
         pot_cnt  <= next_pot_cnt;
         paddle   <= next_paddle;
         pot_done <= next_pot_done;
         dump     <= next_dump;
      end
   end

   // read mux and registered outputs
   logic [7:0] next_rdata;
   logic       next_irq;
   logic       pot_power;

   always_comb begin
      pot_power  = console[CON_POT_POWER];
      next_irq   = |(next_irq_status & next_irq_mask);
      next_rdata = 8'h00;
      if (reg_read) begin
         if (reg_addr >= ADR_PADDLE_BASE) begin
            next_rdata = pot_power ? paddle[reg_addr[2:0]] : POT_MAX;
         end else begin
            case (reg_addr)
               ADR_CONSOLE:    next_rdata = console; // register copy, pins never read
               ADR_SKCTRL:     next_rdata = skctrl;
               ADR_SCAN_CODE:  next_rdata = scan_code;
               ADR_SKSTATUS: begin
                  // top button held and waiting for key release, both active high
                  next_rdata[SKS_SHIFT]    = top_held;
                  next_rdata[SKS_KEY_DOWN] = (kbd_state == CCI_WAIT_RELEASE);
               end
               ADR_IRQ_STATUS: next_rdata = irq_status;
               ADR_IRQ_MASK:   next_rdata = irq_mask;
               ADR_FIRE:       next_rdata = {4'h0, ~fire_sync};
               default:        next_rdata = 8'h00;
            endcase
         end
      end
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         reg_rdata     <= 8'h00;
         irq           <= 1'b0;
         console_lines <= 4'h0;
         pot_dump      <= 1'b1;
      end else begin
         reg_rdata     <= next_rdata;
         irq           <= next_irq;
         console_lines <= next_console[3:0];
         pot_dump      <= next_dump;
      end
   end

endmodule

/* sim/cci_checker.sv */
// checker of register port and pin relations of the controller input block
// assumes it is bound to cci_top and sees only its ports
`timescale 1ns/1ps
module cci_checker
   import cci_pkg::*;
(
   input wire logic                       ref_clk,
   input wire logic                       arst_n,
   input wire logic [cci_pkg::ADDR_W-1:0] reg_addr,
   input wire logic [cci_pkg::DATA_W-1:0] reg_wdata,
   input wire logic                       reg_write,
   input wire logic                       reg_read,
   input wire logic [cci_pkg::DATA_W-1:0] reg_rdata,
   input wire logic                       irq,
   input wire logic [3:0]                 console_lines,
   input wire logic [3:0]                 fire_button_n
);
   import cci_pkg::*;

   // one clock domain, reset disables every check
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!arst_n);

   // register port and pin relations
   a_console_write: assert property (
      reg_write && reg_addr == ADR_CONSOLE |=> console_lines == $past(reg_wdata[3:0]))
      else $error("console lines differ from write");
   a_console_read: assert property (
      reg_read && reg_addr == ADR_CONSOLE |=> reg_rdata[3:0] == $past(console_lines))
      else $error("console readback differs from lines");
   a_rdata_idle: assert property (!reg_read |=> reg_rdata == 8'h00)
      else $error("read data outside read cycle");
   a_unmapped_zero: assert property (reg_read && reg_addr == 4'h7 |=> reg_rdata == 8'h00)
      else $error("unmapped read not zero");
   a_paddle_unpowered: assert property (
      reg_read && reg_addr[3] && !console_lines[2] |=> reg_rdata == POT_MAX)
      else $error("unpowered paddle not at ceiling");
   a_fire_direct: assert property (
      $stable(fire_button_n) [*4] ##0 (reg_read && reg_addr == ADR_FIRE)
      |=> reg_rdata[3:0] == ~$past(fire_button_n))
      else $error("fire bits differ from buttons");
   a_mask_quiet: assert property (
      reg_write && reg_addr == ADR_IRQ_MASK && reg_wdata == 8'h00 |-> ##2 !irq)
      else $error("interrupt high with all masked");
   a_debounce_back: assert property (
      reg_write && reg_addr == ADR_SKCTRL ##1 !reg_write ##1 (reg_read && reg_addr == ADR_SKCTRL)
      |=> reg_rdata[0] == $past(reg_wdata[0], 3))
      else $error("debounce bit lost");
   a_code_top_pair: assert property (
      reg_read && reg_addr == ADR_SCAN_CODE |=> reg_rdata[7] == reg_rdata[6])
      else $error("top code bits differ");

   // main scenarios reached
   c_irq_rise: cover property ($rose(irq));
   c_status_clear: cover property (reg_write && reg_addr == ADR_IRQ_STATUS);
   c_fire_read: cover property (reg_read && reg_addr == ADR_FIRE);
endmodule

bind cci_top cci_checker u_chk (
   .ref_clk       (ref_clk),
   .arst_n        (arst_n),
   .reg_addr      (reg_addr),
   .reg_wdata     (reg_wdata),
   .reg_write     (reg_write),
   .reg_read      (reg_read),
   .reg_rdata     (reg_rdata),
   .irq           (irq),
   .console_lines (console_lines),
   .fire_button_n (fire_button_n)
);

/* sim/cci_pad_model.sv */
// model of four hand controllers: keypad switches, buttons and stick pots
// assumes the bench says what is held; pot power and dump come from the block
`timescale 1ns/1ps
module cci_pad_model (
   input  wire logic             ref_clk,
   input  wire logic [3:0][15:0] key_down,
   input  wire logic [3:0]       top_down,
   input  wire logic [3:0]       fire_down,
   input  wire logic             pot_power,
   input  wire logic             pot_dump,
   output logic      [3:0][15:0] keypad_n,
   output logic      [3:0]       top_button_n,
   output logic      [3:0]       fire_button_n,
   output logic      [7:0]       pot_in
);
   logic [15:0] charge;
   // held switches pull their line low
   assign keypad_n      = ~key_down;
   assign top_button_n  = ~top_down;
   assign fire_button_n = ~fire_down;
   // capacitor charge time since the last dump
   always @(posedge ref_clk) begin
      charge <= (pot_dump || !pot_power) ? 16'h0000 : charge + 16'h0001;
   end
   // even pots horizontal, odd vertical; trips 600 cycles apart, two per scan line, unpowered never trips
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         pot_in[i] = pot_power && (charge > 16'(600 * (i + 1)));
      end
   end
endmodule

/* sim/tb_console_controller_input.sv */
// self-checking bench of the controller input block
// assumes the pad model on the pins and the checker bound to cci_top
`timescale 1ns/1ps
module tb_console_controller_input;
   import cci_pkg::*;
   logic             ref_clk = 1'b0, arst_n = 1'b0, reg_write = 1'b0, reg_read = 1'b0, irq, pot_dump;
   logic [3:0]       reg_addr = 4'h0, console_lines, top_down = 4'h0, fire_down = 4'h0, top_n, fire_n;
   logic [7:0]       reg_wdata = 8'h00, reg_rdata, pot_in;
   logic [3:0][15:0] key_down = 64'h0, keypad_n;
   int               bad_count = 0, total_checks = 0;

   // 20 MHz clock
   always #25 ref_clk = ~ref_clk;

   cci_top u_dut (.ref_clk(ref_clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .irq(irq),
      .console_lines(console_lines), .pot_dump(pot_dump), .keypad_n(keypad_n), .top_button_n(top_n),
      .fire_button_n(fire_n), .pot_in(pot_in));
   cci_pad_model u_pads (.ref_clk(ref_clk), .key_down(key_down), .top_down(top_down), .fire_down(fire_down),
      .pot_power(console_lines[2]), .pot_dump(pot_dump), .keypad_n(keypad_n), .top_button_n(top_n),
      .fire_button_n(fire_n), .pot_in(pot_in));

   // compare and bus tasks
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] v);
      @(posedge ref_clk);
      reg_addr  <= a;
      reg_wdata <= v;
      reg_write <= 1'b1;
      @(posedge ref_clk);
      reg_write <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [7:0] m, input logic [7:0] exp);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge ref_clk);
      reg_read <= 1'b0;
      #1 chk(reg_rdata & m, exp);
   endtask
   task automatic wait_irq(input int n);
      int i = 0;
      do begin
         @(posedge ref_clk) #1;
         i++;
      end while (irq !== 1'b1 && i < n);
      chk({7'h00, irq}, 8'h01);
   endtask
   task automatic end_sim;
      $display("checks %0d, mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   // watchdog against a hang
   initial begin
      repeat (90000) @(posedge ref_clk);
      bad_count++;
      end_sim();
   end

   // test sequence
   initial begin
      repeat (6) @(posedge ref_clk);
      arst_n <= 1'b1;
      for (int a = 0; a < 6; a++) rd(4'(a), 8'hFF, 8'h00);
      rd(4'h7, 8'hFF, 8'h00);
      rd(ADR_PADDLE_BASE, 8'hFF, POT_MAX);
      chk({7'h00, pot_dump}, 8'h01);
      $display("test reset done");
      key_down[0] <= 16'hFFFE;
      top_down[1] <= 1'b1;
      wr(ADR_IRQ_MASK, 8'hC0);
      wr(ADR_CONSOLE, 8'h04);
      rd(ADR_CONSOLE, 8'hFF, 8'h04);
      wr(ADR_SCAN_CODE, 8'hFF);
      rd(ADR_SCAN_CODE, 8'hFF, 8'h00);
      for (int k = 1; k < 16; k++) begin
         for (int j = 0; j < 2; j++) begin
            wait_irq(4 * LINE_CYC);
            rd(ADR_SCAN_CODE, 8'hFF, 8'(2 * k + j));
            rd(ADR_IRQ_STATUS, 8'hFF, 8'h40);
            wr(ADR_IRQ_STATUS, 8'h40);
         end
      end
      $display("test key codes done");
      key_down[0] <= 16'h0004;
      top_down[0] <= 1'b1;
      repeat (4) @(posedge ref_clk);
      rd(ADR_IRQ_STATUS, 8'hFF, 8'h80);
      rd(ADR_SKSTATUS, 8'h0C, 8'h08);
      wr(ADR_IRQ_MASK, 8'h00);
      rd(ADR_IRQ_STATUS, 8'hFF, 8'h80);
      chk({7'h00, irq}, 8'h00);
      wr(ADR_IRQ_MASK, 8'hC0);
      wait_irq(4);
      wr(ADR_IRQ_STATUS, 8'h80);
      $display("test break done");
      wait_irq(8 * LINE_CYC);
      rd(ADR_SCAN_CODE, 8'hFF, 8'hE4);
      wr(ADR_SKCTRL, 8'h01);
      rd(ADR_SKCTRL, 8'hFF, 8'h01);
      rd(ADR_SKSTATUS, 8'h0C, 8'h0C);
      wr(ADR_IRQ_STATUS, 8'h40);
      repeat (3 * LINE_CYC) @(posedge ref_clk);
      rd(ADR_IRQ_STATUS, 8'hFF, 8'h00);
      chk({7'h00, irq}, 8'h00);
      $display("test debounce done");
      @(posedge ref_clk);
      fire_down <= 4'h5;
      repeat (4) @(posedge ref_clk);
      rd(ADR_FIRE, 8'h0F, 8'h05);
      @(posedge ref_clk);
      fire_down <= 4'hA;
      repeat (4) @(posedge ref_clk);
      rd(ADR_FIRE, 8'h0F, 8'h0A);
      chk({7'h00, pot_dump}, 8'h00);
      // pot i trips 600*(i+1) cycles after the first dump ends, one count per scan line
      for (int i = 0; i < 8; i++) rd(ADR_PADDLE_BASE + 4'(i), 8'hFF, 8'((i >> 1) + 1));
      wr(ADR_CONSOLE, 8'h00);
      for (int i = 0; i < 8; i++) rd(ADR_PADDLE_BASE + 4'(i), 8'hFF, POT_MAX);
      $display("test pins done");
      end_sim();
   end
endmodule
